// file: verilog/spi_mem_pkg.sv
// Constants, types and register map of the SPI memory access port.
// Assumes one system clock; SPI pins are sampled, never used as clocks.
package spi_mem_pkg;
    // ----------------------------------------------------------------
    // Register map (11-bit memory addresses)
    // ----------------------------------------------------------------
    localparam logic [10:0] PAGE_SEL_ADDR = 11'h313;
    localparam logic [10:0] TX_PTR_ADDR = 11'h314;
    localparam logic [10:0] RX_PTR_ADDR = 11'h315;
    localparam logic [7:0] PAGE_SEL_RST = 8'h00;
    localparam logic [7:0] TX_PTR_RST = 8'h00;
    localparam logic [7:0] RX_PTR_RST = 8'h00;
    localparam int PAGE_LSB = 0;
    localparam int PAGE_MSB = 3;
    // ----------------------------------------------------------------
    // Memory regions
    // ----------------------------------------------------------------
    localparam logic [2:0] PKT_HI = 3'h0;
    localparam logic [2:0] BACKUP_HI = 3'h1;
    localparam logic [2:0] MCR_HI = 3'h3;
    localparam int PKT_BYTES = 256;
    localparam int BACKUP_BYTES = 64;
    localparam int MCR_BYTES = 256;
    localparam int PRAM_PAGES = 8;
    localparam int PRAM_PAGE_BYTES = 256;
    // ----------------------------------------------------------------
    // Commands
    // ----------------------------------------------------------------
    localparam logic [7:0] PKT_WR_CMD = 8'h10;
    localparam logic [7:0] PKT_RD_CMD = 8'h30;
    localparam logic [7:0] PRAM_WR_CMD = 8'h1e;
    localparam logic [7:0] PRAM_RD_CMD = 8'h3e;
    localparam logic [7:0] DUMMY_CMD = 8'hff;
    localparam logic [4:0] SEQ_WR_PFX = 5'h03;
    localparam logic [4:0] SEQ_RD_PFX = 5'h07;
    localparam logic [4:0] RAND_WR_PFX = 5'h01;
    localparam logic [4:0] RAND_RD_PFX = 5'h05;
    localparam logic [7:0] PRAM_OFFSET_START = 8'h00;
    localparam logic [7:0] JUNK_BYTE = 8'h00;
    localparam int STATUS_READY_BIT = 7;
    localparam int WR_FIFO_DEPTH = 8;

    typedef enum logic [1:0] {RG_PKT, RG_BACKUP, RG_MCR, RG_NONE} region_type;
    typedef enum logic [3:0] {
        CMD_NONE, CMD_PKT_WR, CMD_PKT_RD, CMD_SEQ_WR, CMD_SEQ_RD,
        CMD_RAND_WR, CMD_RAND_RD, CMD_PRAM_WR, CMD_PRAM_RD
    } cmd_type;
    typedef enum logic [1:0] {ST_CMD, ST_ADDR, ST_DATA, ST_IGNORE} st_type;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } spi_pins_type;

    typedef struct packed {
        logic prog;
        logic [10:0] addr;
        logic [7:0] data;
    } wr_word_type;
endpackage

// file: verilog/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes writer and reader share one clock.
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word in
    output logic out_valid, // Word available
    input wire logic out_ready, // Reader takes word
    output logic [WIDTH-1:0] out_data // Word out
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap needs a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_params
        $error("byte_fifo: DEPTH must be a power of two >= 2");
    end

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } fifo_state_type;

    fifo_state_type s_ff, nxt_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;

    assign empty = s_ff.wr_ptr == s_ff.rd_ptr;
    assign full = (s_ff.wr_ptr[AW-1:0] == s_ff.rd_ptr[AW-1:0]) && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[s_ff.rd_ptr[AW-1:0]];

    always_comb
    begin
        nxt_s = s_ff;
        if (in_valid && !full)
            nxt_s.wr_ptr = s_ff.wr_ptr + 1'b1;
        if (out_ready && !empty)
            nxt_s.rd_ptr = s_ff.rd_ptr + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
        if (in_valid && !full)
            mem[s_ff.wr_ptr[AW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

// file: verilog/spi_memory_access_port.sv
// SPI slave that decodes memory access commands into the packet,
// backup, modem configuration and program RAMs.
// Assumes SPI mode 0 and a system clock at least 8x the SPI clock.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R1 - Buffer write stores bytes at tx start pointer plus rising index.
// R2 - Sequential write takes address high bits in command, then low byte, increments.
// R3 - Chip select high ends command; next low starts with a command byte.
// R4 - Master keeps sequential writes within 256, 256 or 64 bytes per region.
// R5 - Random write takes repeated low address and data pairs.
// R6 - Master adds relative position to rx or tx start pointer.
// R7 - Program RAM write 0x1e plus address 0x00 fills page from offset zero.
// R8 - Program RAM is eight 256-byte pages chosen by page field.
// R9 - Master loads code from page 0 in full 256-byte pages.
// R10 - Buffer read returns rx start pointer plus index per dummy.
// R11 - Master discards first byte returned after buffer read command.
// R12 - Sequential read: address, junk dummy, then valid data.
// R13 - Sequential read advances address for each further dummy.
// R14 - Random read returns addressed data during second dummy.
// R15 - Each further random read is new low address plus two dummies.
// R16 - Master sends 0xff in every dummy position.
// R17 - Program RAM read follows sequential read on selected page.
// R18 - Master commands only while the ready bit is high.
// R19 - Bytes move MSB first, one bit per SPI clock while selected.
module spi_memory_access_port (
    input wire logic clk_sys, // System clock, 25 MHz
    input wire logic rst, // Synchronous reset
    input wire spi_mem_pkg::spi_pins_type pins, // SPI clock, select, data in
    output logic miso, // Serial data out
    output logic miso_oe, // Drives miso while selected
    output logic access_ready // Write buffer has room
);
    import spi_mem_pkg::*;

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic mosi_s1;
        logic mosi_s2;
        st_type st;
        cmd_type kind;
        logic [2:0] bit_cnt;
        logic [7:0] rx;
        logic [7:0] tx_sh;
        logic [7:0] tx_next;
        logic load_pend;
        logic rd_phase;
        logic [10:0] addr;
        logic push_valid;
        wr_word_type push;
        logic [7:0] page;
        logic [7:0] tx_ptr;
        logic [7:0] rx_ptr;
        logic miso;
        logic miso_oe;
        logic access_ready;
    } port_state_type;

    port_state_type s_ff, nxt_s;

    logic [7:0] pkt_ram [PKT_BYTES];
    logic [7:0] backup_ram [BACKUP_BYTES];
    logic [7:0] modem_config_ram [MCR_BYTES];
    logic [7:0] pram [PRAM_PAGES*PRAM_PAGE_BYTES];

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [7:0] rd_data;
    logic [7:0] status;
    logic fifo_in_ready;
    logic drain_valid;
    logic drain_ready;
    logic drain_fire;
    wr_word_type drain;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic region_type region_of(input logic [10:0] a);
        if (a[10:8] == PKT_HI)
            return RG_PKT;
        else if (a[10:8] == BACKUP_HI && a[7:6] == 2'h0)
            return RG_BACKUP;
        else if (a[10:8] == MCR_HI)
            return RG_MCR;
        else
            return RG_NONE;
    endfunction

    // Program RAM codes overlap the sequential prefixes; test them first
    function automatic cmd_type cmd_of(input logic [7:0] b);
        if (b == PKT_WR_CMD)
            return CMD_PKT_WR;
        else if (b == PKT_RD_CMD)
            return CMD_PKT_RD;
        else if (b == PRAM_WR_CMD)
            return CMD_PRAM_WR;
        else if (b == PRAM_RD_CMD)
            return CMD_PRAM_RD;
        else if (b[7:3] == SEQ_WR_PFX)
            return CMD_SEQ_WR;
        else if (b[7:3] == SEQ_RD_PFX)
            return CMD_SEQ_RD;
        else if (b[7:3] == RAND_WR_PFX)
            return CMD_RAND_WR;
        else if (b[7:3] == RAND_RD_PFX)
            return CMD_RAND_RD;
        else
            return CMD_NONE;
    endfunction

    // Pointer and page accesses wrap inside their 256-byte area
    function automatic logic [10:0] next_addr(input cmd_type k, input logic [10:0] a);
        if (k == CMD_PKT_WR || k == CMD_PKT_RD || k == CMD_PRAM_WR || k == CMD_PRAM_RD)
            return {a[10:8], a[7:0] + 8'h01};
        else
            return a + 11'h001;
    endfunction

    function automatic logic is_write(input cmd_type k);
        return k == CMD_PKT_WR || k == CMD_SEQ_WR || k == CMD_RAND_WR || k == CMD_PRAM_WR;
    endfunction

    // ----------------------------------------------------------------
    // Edges and byte framing
    // ----------------------------------------------------------------
    assign sclk_rise = s_ff.sclk_s2 && !s_ff.sclk_d;
    assign sclk_fall = !s_ff.sclk_s2 && s_ff.sclk_d;
    assign cs_fall = !s_ff.cs_s2 && s_ff.cs_d;
    // R19 MSB first framing
    assign rx_byte = {s_ff.rx[6:0], s_ff.mosi_s2};
    assign byte_done = sclk_rise && !s_ff.cs_s2 && !cs_fall && s_ff.bit_cnt == 3'h7;
    assign status = {s_ff.access_ready, 7'h00};

    // ----------------------------------------------------------------
    // Memory read port
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_data = 8'h00;
        // R8 page select
        if (s_ff.kind == CMD_PRAM_RD)
            rd_data = pram[{s_ff.page[2:0], s_ff.addr[7:0]}];
        else
        begin
            unique case (region_of(s_ff.addr))
                RG_PKT: rd_data = pkt_ram[s_ff.addr[7:0]];
                RG_BACKUP: rd_data = backup_ram[s_ff.addr[5:0]];
                RG_MCR:
                begin
                    if (s_ff.addr == PAGE_SEL_ADDR)
                        rd_data = s_ff.page;
                    else if (s_ff.addr == TX_PTR_ADDR)
                        rd_data = s_ff.tx_ptr;
                    else if (s_ff.addr == RX_PTR_ADDR)
                        rd_data = s_ff.rx_ptr;
                    else
                        rd_data = modem_config_ram[s_ff.addr[7:0]];
                end
                RG_NONE: rd_data = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Command engine
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.sclk_s1 = pins.sclk;
        nxt_s.sclk_s2 = s_ff.sclk_s1;
        nxt_s.sclk_d = s_ff.sclk_s2;
        nxt_s.cs_s1 = pins.cs_n;
        nxt_s.cs_s2 = s_ff.cs_s1;
        nxt_s.cs_d = s_ff.cs_s2;
        nxt_s.mosi_s1 = pins.mosi;
        nxt_s.mosi_s2 = s_ff.mosi_s1;
        nxt_s.push_valid = 1'b0;
        nxt_s.access_ready = fifo_in_ready;
        if (s_ff.cs_s2)
        begin
            // R3 deselect ends command
            nxt_s.st = ST_CMD;
            nxt_s.kind = CMD_NONE;
            nxt_s.bit_cnt = 3'h0;
            nxt_s.load_pend = 1'b0;
            nxt_s.miso_oe = 1'b0;
        end
        else if (cs_fall)
        begin
            nxt_s.st = ST_CMD;
            nxt_s.bit_cnt = 3'h0;
            nxt_s.miso_oe = 1'b1;
            nxt_s.miso = status[7];
            nxt_s.tx_sh = {status[6:0], 1'b0};
        end
        else
        begin
            if (sclk_rise)
            begin
                nxt_s.rx = rx_byte;
                nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
            end
            if (byte_done)
            begin
                nxt_s.load_pend = 1'b1;
                nxt_s.tx_next = JUNK_BYTE;
                unique case (s_ff.st)
                    ST_CMD:
                    begin
                        nxt_s.kind = cmd_of(rx_byte);
                        nxt_s.addr = {rx_byte[2:0], 8'h00};
                        nxt_s.rd_phase = 1'b0;
                        unique case (cmd_of(rx_byte))
                            // R1 start at tx pointer
                            CMD_PKT_WR:
                            begin
                                nxt_s.addr = {PKT_HI, s_ff.tx_ptr};
                                nxt_s.st = ST_DATA;
                            end
                            // R10 start at rx pointer
                            CMD_PKT_RD:
                            begin
                                nxt_s.addr = {PKT_HI, s_ff.rx_ptr};
                                nxt_s.st = ST_DATA;
                            end
                            CMD_NONE: nxt_s.st = ST_IGNORE;
                            default: nxt_s.st = ST_ADDR;
                        endcase
                    end
                    ST_ADDR:
                    begin
                        nxt_s.addr = {s_ff.addr[10:8], rx_byte};
                        // R7 page offset zero
                        if (s_ff.kind == CMD_PRAM_WR)
                            nxt_s.addr = {s_ff.addr[10:8], PRAM_OFFSET_START};
                        nxt_s.rd_phase = 1'b0;
                        nxt_s.st = ST_DATA;
                    end
                    ST_DATA:
                    begin
                        if (is_write(s_ff.kind))
                        begin
                            // R1 R2 R5 queue the write
                            nxt_s.push_valid = 1'b1;
                            nxt_s.push = '{prog: s_ff.kind == CMD_PRAM_WR,
                                           addr: s_ff.addr, data: rx_byte};
                            if (s_ff.kind == CMD_RAND_WR)
                                nxt_s.st = ST_ADDR;
                            else
                                nxt_s.addr = next_addr(s_ff.kind, s_ff.addr);
                        end
                        else if (s_ff.kind == CMD_RAND_RD)
                        begin
                            // R14 R15 data on second dummy
                            if (!s_ff.rd_phase)
                            begin
                                nxt_s.tx_next = rd_data;
                                nxt_s.rd_phase = 1'b1;
                            end
                            else
                                nxt_s.st = ST_ADDR;
                        end
                        else
                        begin
                            // R12 R13 R17 stream one byte ahead
                            nxt_s.tx_next = rd_data;
                            nxt_s.addr = next_addr(s_ff.kind, s_ff.addr);
                        end
                    end
                    ST_IGNORE: nxt_s.st = ST_IGNORE;
                endcase
            end
            // R19 shift out on falling edge
            if (sclk_fall)
            begin
                if (s_ff.load_pend)
                begin
                    nxt_s.miso = s_ff.tx_next[7];
                    nxt_s.tx_sh = {s_ff.tx_next[6:0], 1'b0};
                    nxt_s.load_pend = 1'b0;
                end
                else
                begin
                    nxt_s.miso = s_ff.tx_sh[7];
                    nxt_s.tx_sh = {s_ff.tx_sh[6:0], 1'b0};
                end
            end
        end
        // Register writes retire through the buffer, in order
        if (drain_fire && !drain.prog)
        begin
            if (drain.addr == PAGE_SEL_ADDR)
                nxt_s.page = {4'h0, drain.data[PAGE_MSB:PAGE_LSB]};
            if (drain.addr == TX_PTR_ADDR)
                nxt_s.tx_ptr = drain.data;
            if (drain.addr == RX_PTR_ADDR)
                nxt_s.rx_ptr = drain.data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_ff <= '0;
            s_ff.sclk_s1 <= 1'b0;
            s_ff.cs_s1 <= 1'b1;
            s_ff.cs_s2 <= 1'b1;
            s_ff.cs_d <= 1'b1;
            s_ff.st <= ST_CMD;
            s_ff.kind <= CMD_NONE;
            s_ff.page <= PAGE_SEL_RST;
            s_ff.tx_ptr <= TX_PTR_RST;
            s_ff.rx_ptr <= RX_PTR_RST;
        end
        else
            s_ff <= nxt_s;
    end

    // ----------------------------------------------------------------
    // Write buffer and memory write port
    // ----------------------------------------------------------------
    // Single memory port: a byte fetch stalls the drain for that cycle
    assign drain_ready = !byte_done;
    assign drain_fire = drain_valid && drain_ready;

    byte_fifo #(
        .WIDTH($bits(wr_word_type)),
        .DEPTH(WR_FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(s_ff.push_valid),
        .in_ready(fifo_in_ready),
        .in_data(s_ff.push),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain)
    );

    always_ff @(posedge clk_sys)
    begin
        if (drain_fire)
        begin
            // R8 page selects program RAM bank
            if (drain.prog)
                pram[{s_ff.page[2:0], drain.addr[7:0]}] <= drain.data;
            else if (region_of(drain.addr) == RG_PKT)
                pkt_ram[drain.addr[7:0]] <= drain.data;
            else if (region_of(drain.addr) == RG_BACKUP)
                backup_ram[drain.addr[5:0]] <= drain.data;
            else if (region_of(drain.addr) == RG_MCR)
                modem_config_ram[drain.addr[7:0]] <= drain.data;
        end
    end

    assign miso = s_ff.miso;
    assign miso_oe = s_ff.miso_oe;
    assign access_ready = s_ff.access_ready;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_cs_end;
        s_ff.cs_s2 |=> s_ff.st == ST_CMD && !s_ff.miso_oe;
    endproperty
    a_cs_end: assert property (p_cs_end) else $error("deselect did not end command"); // R3

    property p_pkt_wr_base;
        byte_done && s_ff.st == ST_CMD && rx_byte == PKT_WR_CMD
            |=> s_ff.addr == {PKT_HI, $past(s_ff.tx_ptr)} && s_ff.st == ST_DATA;
    endproperty
    a_pkt_wr_base: assert property (p_pkt_wr_base) else $error("bad buffer write base"); // R1

    property p_seq_wr_inc;
        byte_done && s_ff.st == ST_DATA && s_ff.kind == CMD_SEQ_WR
            |=> s_ff.addr == 11'($past(s_ff.addr) + 11'h001) && s_ff.push_valid;
    endproperty
    a_seq_wr_inc: assert property (p_seq_wr_inc) else $error("write address not advanced"); // R2

    property p_rand_pair;
        byte_done && s_ff.st == ST_DATA && s_ff.kind == CMD_RAND_WR
            |=> s_ff.push.addr == $past(s_ff.addr) && s_ff.push.data == $past(rx_byte)
            && s_ff.st == ST_ADDR;
    endproperty
    a_rand_pair: assert property (p_rand_pair) else $error("random write pair lost"); // R5

    property p_pram_zero;
        byte_done && s_ff.st == ST_ADDR && s_ff.kind == CMD_PRAM_WR
            |=> s_ff.addr[7:0] == PRAM_OFFSET_START;
    endproperty
    a_pram_zero: assert property (p_pram_zero) else $error("program write not at zero"); // R7

    property p_pkt_rd_base;
        byte_done && s_ff.st == ST_CMD && rx_byte == PKT_RD_CMD
            |=> s_ff.addr == {PKT_HI, $past(s_ff.rx_ptr)} && s_ff.tx_next == JUNK_BYTE;
    endproperty
    a_pkt_rd_base: assert property (p_pkt_rd_base) else $error("bad buffer read base"); // R10

    property p_seq_rd_stream;
        byte_done && s_ff.st == ST_DATA && s_ff.kind == CMD_SEQ_RD
            |=> s_ff.tx_next == $past(rd_data)
            && s_ff.addr == 11'($past(s_ff.addr) + 11'h001);
    endproperty
    a_seq_rd_stream: assert property (p_seq_rd_stream) else $error("read stream broken"); // R13

    property p_rand_rd_turn;
        byte_done && s_ff.st == ST_DATA && s_ff.kind == CMD_RAND_RD && s_ff.rd_phase
            |=> s_ff.st == ST_ADDR;
    endproperty
    a_rand_rd_turn: assert property (p_rand_rd_turn) else $error("random read not rearmed"); // R15

    c_pkt_wr: cover property (drain_fire && !drain.prog);
    c_pram_wr: cover property (drain_fire && drain.prog);
    c_rand_rd: cover property (byte_done && s_ff.kind == CMD_RAND_RD && s_ff.rd_phase);
endmodule
`default_nettype wire

// file: verification/spi_host_model.sv
// Host-side SPI master model, mode 0, driving the port's pins.
// Assumes the bench clock; half an SPI period is four system clocks.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    input wire logic clk_sys, // System clock
    input wire logic miso, // Serial data from the port
    input wire logic access_ready, // Ready flag of the status byte
    output var spi_mem_pkg::spi_pins_type pins // Clock, select, data out
);
    import spi_mem_pkg::*;
    initial pins = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
    task automatic half();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task automatic open_frame();
        int n = 0;
        while (access_ready !== 1'b1 && n < 50)
        begin
            half();
            n++;
        end
        pins.cs_n = 1'b0;
        half();
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            pins.mosi = tx[i];
            half();
            pins.sclk = 1'b1;
            rx[i] = miso;
            half();
            pins.sclk = 1'b0;
        end
    endtask
    task automatic close_frame();
        half();
        pins.cs_n = 1'b1;
        // Released data line must not look like a held bit
        pins.mosi = ~pins.mosi;
        half();
        half();
    endtask
endmodule
`default_nettype wire

// file: verification/spi_memory_access_port_test.sv
// Self-checking bench for the SPI memory access port.
// Assumes the host model drives all SPI pins; dummies are 0xff.
`timescale 1ns/1ns
`default_nettype none
module spi_memory_access_port_test;
    import spi_mem_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    spi_pins_type pins;
    logic miso;
    logic miso_oe;
    logic access_ready;
    logic miso_line;
    logic [7:0] rx_q[$];
    logic [7:0] q[$];
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    always #20 clk_sys = ~clk_sys;
    spi_memory_access_port spi_memory_access_port_i (.clk_sys(clk_sys), .rst(rst),
        .pins(pins), .miso(miso), .miso_oe(miso_oe), .access_ready(access_ready));
    // Deselected output is undriven with no pull; model it as the inverse
    assign miso_line = miso_oe ? miso : ~miso;
    spi_host_model spi_host_model_i (.clk_sys(clk_sys), .miso(miso_line),
        .access_ready(access_ready), .pins(pins));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [7:0] tx[$]);
        logic [7:0] r;
        rx_q = {};
        spi_host_model_i.open_frame();
        foreach (tx[i])
        begin
            spi_host_model_i.xfer(tx[i], r);
            rx_q.push_back(r);
        end
        spi_host_model_i.close_frame();
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Long program upload sets the ceiling
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            final_report();
        end
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 chk({6'h0, access_ready, miso_oe}, 8'h02);
        run('{8'h2b, 8'h13, 8'hff, 8'hff, 8'h14, 8'hff, 8'hff, 8'h15, 8'hff, 8'hff});
        chk(rx_q[0], 8'h80);
        for (int i = 1; i < 4; i++) chk(rx_q[3*i], 8'h00);
        $display("test reset done");
        run('{8'h1b, 8'h3e, 8'ha5, 8'h5a});
        run('{8'h3b, 8'h3e, 8'hff, 8'hff, 8'hff});
        chk(rx_q[2], 8'h00);
        chk(rx_q[3], 8'ha5);
        chk(rx_q[4], 8'h5a);
        run('{8'h19, 8'h3f, 8'hc3, 8'h3c});
        run('{8'h29, 8'h3f, 8'hff, 8'hff, 8'h40, 8'hff, 8'hff});
        chk(rx_q[3], 8'hc3);
        chk(rx_q[6], 8'h00);
        $display("test sequential done");
        run('{8'h0b, 8'h14, 8'h20, 8'h15, 8'h21});
        run('{8'h10, 8'h11, 8'h22, 8'h33});
        run('{8'h28, 8'h20, 8'hff, 8'hff, 8'h21, 8'hff, 8'hff, 8'h22, 8'hff, 8'hff});
        for (int i = 0; i < 3; i++) chk(rx_q[3*i+3], 8'(8'h11 * (i + 1)));
        run('{8'h30, 8'hff, 8'hff, 8'hff});
        chk(rx_q[1], 8'h00);
        chk(rx_q[2], 8'h22);
        chk(rx_q[3], 8'h33);
        $display("test packet done");
        q = '{8'h1e, 8'h00};
        for (int i = 0; i < 256; i++) q.push_back(8'(i) ^ 8'h5a);
        run(q);
        run('{8'h0b, 8'h13, 8'h01});
        run('{8'h1e, 8'h00, 8'ha1});
        run('{8'h3e, 8'h00, 8'hff, 8'hff});
        chk(rx_q[3], 8'ha1);
        run('{8'h0b, 8'h13, 8'h00});
        run('{8'h3e, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff});
        chk(rx_q[2], 8'h00);
        chk(rx_q[3], 8'ha4);
        chk(rx_q[4], 8'ha5);
        chk(rx_q[5], 8'h5a);
        $display("test program done");
        run('{8'h1b, 8'h3e});
        run('{8'hff, 8'hff});
        chk(rx_q[1], 8'h00);
        run('{8'h2a, 8'h00, 8'hff, 8'hff});
        chk(rx_q[3], 8'h00);
        run('{8'h3b, 8'h3e, 8'hff, 8'hff});
        chk(rx_q[3], 8'ha5);
        $display("test refusal done");
        final_report();
    end
endmodule
`default_nettype wire
